// ==== rtl/frp_flash_ctrl.v ====
// Functional notes
// - serial mode checks seven id bytes unless reset vector bytes all erased.
// - id mismatch makes the device refuse every serial programmer command.
// - parallel lockout active when protect-disable is 1 and protect is 0.
// - lockout blocks parallel reads, rewrites and erases.
// - erasing the option block removes lockout; option reads as all ones.
// - option bit 0 picks watchdog autostart, bit 7 count-source protect.
// - option bits 5:4 select 3.80, 2.85, 2.35 or 1.90 V threshold.
// - one selected threshold feeds power-on and level-0 monitor reset.
// - erase may be suspended; reads and programming allowed while suspended.
// - first rewrite mode runs from ram; cpu keeps running during rewrite.
// - second rewrite mode holds cpu and freezes ports during rewrite.
// - after program, erase or suspend entry flash returns to read-array.
// - suspend by sw bits (first mode) or enabled irq (both modes).
// - status resets with ready at 1, lock monitor undefined, rest 0.
// - software may clear irq flags bits 0 and 1 but never set them.
// - program and erase error flags read-only, also set on command error.
// - bit 6 reads 1 while suspended; bit 7 is 0 busy, 1 ready.
// - status bit 3 always reads 0.
// - bit 2 lock monitor: 0 locked, 1 not, updated by lock-read.
// - with ready irq enabled, busy to ready sets the ready irq flag.
// - clear-status command also clears the access error flag.
`timescale 1ns/1ps
`default_nettype none
`include "frp_defines.vh"
module frp_flash_ctrl #(
  parameter PROG_CYC = `FRP_PROG_CYC,
  parameter ERASE_CYC = `FRP_ERASE_CYC,
  parameter ID_BYTES = 7
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire serial_mode_i,
  input wire [23:0] reset_vector_i,
  input wire [8*ID_BYTES-1:0] id_stored_i,
  input wire [8*ID_BYTES-1:0] id_rx_i,
  input wire id_rx_valid_i,
  input wire ser_cmd_valid_i,
  output wire ser_cmd_accept_o,
  input wire par_mode_i,
  input wire par_access_i,
  output wire par_access_grant_o,
  input wire block_locked_i,
  input wire op_error_i,
  input wire busy_block_access_i,
  input wire irq_pending_i,
  output wire read_array_o,
  output wire cpu_hold_o,
  output wire port_freeze_o,
  output wire watchdog_autostart_sel_o,
  output wire count_source_protect_init_o,
  output wire monitor_reset_start_o,
  output wire [1:0] vlevel_sel_o,
  output wire por_vlevel_sel_o,
  output wire mon0_vlevel_sel_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_PROG = 2'd1;
  localparam ST_ERASE = 2'd2;
  localparam ST_LOCK = 2'd3;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [31:0] cnt_ff;
  reg [31:0] nxt_cnt;
  reg suspend_ff;
  reg nxt_suspend;
  reg ready_irq_ff;
  reg acc_err_irq_ff;
  reg prog_err_ff;
  reg erase_err_ff;
  reg lock_mon_ff;
  reg [7:0] ctrl0_ff;
  reg [2:0] ctrl2_ff;
  reg [7:0] option_ff;
  reg id_ok_ff;
  reg erase_opt_ff;
  reg busy_q_ff;
  // an erase parked under a program started during suspend
  reg parked_ff;
  reg nxt_parked;
  reg [31:0] park_cnt_ff;
  reg [31:0] nxt_park_cnt;

  wire busy = (state_ff != ST_IDLE) && !suspend_ff;
  wire ready = !busy;
  wire rewrite_en = ctrl0_ff[`FRP_C0_REWRITE_EN];
  wire rom_run = ctrl0_ff[`FRP_C0_ROM_RUN_MODE];
  wire wr_status = wr_i && (addr_i == `FRP_ADDR_STATUS);
  wire wr_ctrl0 = wr_i && (addr_i == `FRP_ADDR_CTRL0);
  wire wr_ctrl2 = wr_i && (addr_i == `FRP_ADDR_CTRL2);
  wire wr_opt = wr_i && (addr_i == `FRP_ADDR_OPTION);
  wire wr_cmd = wr_i && (addr_i == `FRP_ADDR_CMD) && rewrite_en;
  wire cmd_prog = wr_cmd && (wdata_i == `FRP_CMD_PROGRAM);
  wire cmd_erase = wr_cmd && ((wdata_i == `FRP_CMD_ERASE) ||
                              (wdata_i == `FRP_CMD_ERASE_OPT));
  wire cmd_lock = wr_cmd && (wdata_i == `FRP_CMD_LOCK_READ);
  wire cmd_clr = wr_cmd && (wdata_i == `FRP_CMD_CLR_STATUS);
  wire idle = (state_ff == ST_IDLE);
  // a program may start while idle or while an erase is suspended
  wire start_prog = cmd_prog && (idle || suspend_ff);
  wire start_erase = cmd_erase && idle;
  wire start_lock = cmd_lock && idle;
  wire abort = wr_ctrl0 && wdata_i[`FRP_C0_ABORT] && busy;
  wire done = busy && (cnt_ff == 32'd0);

  // suspend request; sw bit only honoured in the ram-run mode
  wire susp_req = ctrl2_ff[`FRP_C2_SUSPEND_EN] &&
    ((ctrl2_ff[`FRP_C2_SW_SUSPEND] && !rom_run) ||
     (ctrl2_ff[`FRP_C2_IRQ_SUSPEND_EN] && irq_pending_i));
  wire enter_susp = (state_ff == ST_ERASE) && !suspend_ff && susp_req;
  wire lockout = option_ff[`FRP_OPT_PROT_DIS] &&
                 !option_ff[`FRP_OPT_PROT];

  // id compare, one byte lane per loop pass
  wire [ID_BYTES-1:0] id_byte_eq;
  genvar gi;
  generate
    for (gi = 0; gi < ID_BYTES; gi = gi + 1) begin : g_id
      assign id_byte_eq[gi] = (id_rx_i[8*gi+7:8*gi] ==
                               id_stored_i[8*gi+7:8*gi]);
    end
  endgenerate
  wire id_match = &id_byte_eq;
  // an erased reset vector means a blank part: no check needed
  wire vector_erased = (reset_vector_i == 24'hff_ffff);

  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_suspend = suspend_ff;
    nxt_parked = parked_ff;
    nxt_park_cnt = park_cnt_ff;
    if (abort) begin
      nxt_state = ST_IDLE;
      nxt_suspend = 1'b0;
      nxt_parked = 1'b0;
    end else if (enter_susp) begin
      nxt_suspend = 1'b1;
    end else if (suspend_ff) begin
      // a program during suspend runs, then the erase waits again
      if (start_prog) begin
        nxt_state = ST_PROG;
        nxt_cnt = PROG_CYC - 1;
        nxt_suspend = 1'b0;
        nxt_parked = 1'b1;
        nxt_park_cnt = cnt_ff;
      end else if (!ctrl2_ff[`FRP_C2_SUSPEND_EN]) begin
        nxt_suspend = 1'b0;
      end
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_prog) begin
            nxt_state = ST_PROG;
            nxt_cnt = PROG_CYC - 1;
          end else if (start_erase) begin
            nxt_state = ST_ERASE;
            nxt_cnt = ERASE_CYC - 1;
          end else if (start_lock) begin
            nxt_state = ST_LOCK;
            nxt_cnt = `FRP_LOCK_CYC - 1;
          end
        end
        ST_PROG: begin
          if (done && parked_ff) begin
            // the parked erase comes back still suspended
            nxt_state = ST_ERASE;
            nxt_cnt = park_cnt_ff;
            nxt_suspend = 1'b1;
            nxt_parked = 1'b0;
          end else if (done) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_cnt = cnt_ff - 32'd1;
          end
        end
        ST_ERASE, ST_LOCK: begin
          if (done) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_cnt = cnt_ff - 32'd1;
          end
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 32'd0;
      suspend_ff <= 1'b0;
      erase_opt_ff <= 1'b0;
      parked_ff <= 1'b0;
      park_cnt_ff <= 32'd0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      suspend_ff <= nxt_suspend;
      parked_ff <= nxt_parked;
      park_cnt_ff <= nxt_park_cnt;
      if (start_erase) begin
        erase_opt_ff <= (wdata_i == `FRP_CMD_ERASE_OPT);
      end
    end
  end

  // status flags; hardware set wins over software clear
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_q_ff <= 1'b0;
    end else begin
      busy_q_ff <= busy;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ready_irq_ff <= 1'b0;
    end else if (busy_q_ff && !busy && ctrl0_ff[`FRP_C0_READY_IE]) begin
      ready_irq_ff <= 1'b1;
    end else if (wr_status && !wdata_i[`FRP_ST_READY_IRQ]) begin
      ready_irq_ff <= 1'b0;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      acc_err_irq_ff <= 1'b0;
      prog_err_ff <= 1'b0;
      erase_err_ff <= 1'b0;
      lock_mon_ff <= 1'b0;
    end else begin
      if ((busy && busy_block_access_i &&
           ctrl0_ff[`FRP_C0_ACC_ERR_IE]) ||
          (busy && op_error_i && ctrl0_ff[`FRP_C0_CMD_ERR_IE])) begin
        acc_err_irq_ff <= 1'b1;
      end else if ((wr_status && !wdata_i[`FRP_ST_ACC_ERR_IRQ]) ||
                   cmd_clr) begin
        acc_err_irq_ff <= 1'b0;
      end
      if (busy && op_error_i && state_ff == ST_PROG) begin
        prog_err_ff <= 1'b1;
      end else if (cmd_clr) begin
        prog_err_ff <= 1'b0;
      end
      if (busy && op_error_i && state_ff != ST_PROG) begin
        erase_err_ff <= 1'b1;
      end else if (cmd_clr) begin
        erase_err_ff <= 1'b0;
      end
      if (done && state_ff == ST_LOCK) begin
        lock_mon_ff <= !block_locked_i;
      end
    end
  end

  // control registers and option word
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl0_ff <= `FRP_CTRL_RST;
      ctrl2_ff <= 3'b000;
      option_ff <= `FRP_OPTION_ERASED;
    end else begin
      if (wr_ctrl0) begin
        // the abort bit is a pulse and never stored
        ctrl0_ff <= wdata_i & 8'hef;
      end
      if (wr_ctrl2) begin
        ctrl2_ff <= wdata_i[2:0];
      end
      if (done && state_ff == ST_ERASE && erase_opt_ff) begin
        option_ff <= `FRP_OPTION_ERASED;
      end else if (wr_opt) begin
        // flash cells only program ones to zeros
        option_ff <= option_ff & wdata_i;
      end
    end
  end

  // id check latched when the programmer sends its codes
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      id_ok_ff <= 1'b0;
    end else if (id_rx_valid_i) begin
      id_ok_ff <= vector_erased || id_match;
    end
  end

  // status word assembled field by field
  wire [7:0] status_word;
  assign status_word[`FRP_ST_READY_IRQ] = ready_irq_ff;
  assign status_word[`FRP_ST_ACC_ERR_IRQ] = acc_err_irq_ff;
  assign status_word[`FRP_ST_LOCK_MON] = lock_mon_ff;
  assign status_word[`FRP_ST_UNUSED] = 1'b0;
  assign status_word[`FRP_ST_PROG_ERR] = prog_err_ff;
  assign status_word[`FRP_ST_ERASE_ERR] = erase_err_ff;
  assign status_word[`FRP_ST_SUSPEND] = suspend_ff;
  assign status_word[`FRP_ST_READY] = ready;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `FRP_ADDR_STATUS: rdata_o <= status_word;
        `FRP_ADDR_CTRL0: rdata_o <= ctrl0_ff;
        `FRP_ADDR_CTRL2: rdata_o <= {5'h00, ctrl2_ff};
        `FRP_ADDR_OPTION: rdata_o <= option_ff;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  assign ser_cmd_accept_o = serial_mode_i && ser_cmd_valid_i &&
                            id_ok_ff;
  assign par_access_grant_o = par_mode_i && par_access_i &&
                              !lockout;
  assign read_array_o = !busy;
  // ram-run mode leaves the cpu running
  assign cpu_hold_o = rom_run && busy &&
                      state_ff != ST_LOCK;
  assign port_freeze_o = cpu_hold_o;
  assign watchdog_autostart_sel_o = option_ff[`FRP_OPT_WDT_AUTO];
  assign count_source_protect_init_o = option_ff[`FRP_OPT_CSP_INIT];
  assign monitor_reset_start_o = option_ff[`FRP_OPT_MON_RESET];
  assign vlevel_sel_o = {option_ff[`FRP_OPT_VLEVEL_HI],
                         option_ff[`FRP_OPT_VLEVEL_LO]};
  // both resets share the one selected level
  assign por_vlevel_sel_o = ^vlevel_sel_o ? 1'b1 : 1'b0;
  assign mon0_vlevel_sel_o = por_vlevel_sel_o;
endmodule
`default_nettype wire

// ==== rtl/frp_defines.vh ====
`ifndef FRP_DEFINES_VH
`define FRP_DEFINES_VH
// register offsets (byte addresses on the plain port)
`define FRP_ADDR_STATUS 16'h01b2
`define FRP_ADDR_CTRL0 16'h01b4
`define FRP_ADDR_CTRL2 16'h01b6
`define FRP_ADDR_OPTION 16'hffff
`define FRP_ADDR_CMD 16'h01b8
// status fields
`define FRP_ST_READY_IRQ 0
`define FRP_ST_ACC_ERR_IRQ 1
`define FRP_ST_LOCK_MON 2
`define FRP_ST_UNUSED 3
`define FRP_ST_PROG_ERR 4
`define FRP_ST_ERASE_ERR 5
`define FRP_ST_SUSPEND 6
`define FRP_ST_READY 7
// control zero fields
`define FRP_C0_REWRITE_EN 1
`define FRP_C0_ROM_RUN_MODE 2
`define FRP_C0_ABORT 4
`define FRP_C0_CMD_ERR_IE 5
`define FRP_C0_ACC_ERR_IE 6
`define FRP_C0_READY_IE 7
// control two fields
`define FRP_C2_SUSPEND_EN 0
`define FRP_C2_SW_SUSPEND 1
`define FRP_C2_IRQ_SUSPEND_EN 2
// option select word fields
`define FRP_OPT_WDT_AUTO 0
`define FRP_OPT_PROT_DIS 2
`define FRP_OPT_PROT 3
`define FRP_OPT_VLEVEL_LO 4
`define FRP_OPT_VLEVEL_HI 5
`define FRP_OPT_MON_RESET 6
`define FRP_OPT_CSP_INIT 7
// reset and erased values
`define FRP_STATUS_RST 8'h80
`define FRP_OPTION_ERASED 8'hff
`define FRP_CTRL_RST 8'h00
// command codes on the command register
`define FRP_CMD_PROGRAM 8'h01
`define FRP_CMD_ERASE 8'h02
`define FRP_CMD_LOCK_READ 8'h03
`define FRP_CMD_CLR_STATUS 8'h04
`define FRP_CMD_ERASE_OPT 8'h05
// timing
`define FRP_CLK_NS 10
`define FRP_PROG_NS 1000
`define FRP_ERASE_NS 5000
`define FRP_PROG_CYC (`FRP_PROG_NS / `FRP_CLK_NS)
`define FRP_ERASE_CYC (`FRP_ERASE_NS / `FRP_CLK_NS)
`define FRP_LOCK_CYC 4
`endif

// ==== sim/frp_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "frp_defines.vh"
module frp_checker #(
  parameter ID_BYTES = 7
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic serial_mode_i,
  input wire logic [23:0] reset_vector_i,
  input wire logic [8*ID_BYTES-1:0] id_stored_i,
  input wire logic [8*ID_BYTES-1:0] id_rx_i,
  input wire logic id_rx_valid_i,
  input wire logic ser_cmd_valid_i,
  input wire logic ser_cmd_accept_o,
  input wire logic read_array_o,
  input wire logic cpu_hold_o,
  input wire logic port_freeze_o,
  input wire logic [1:0] vlevel_sel_o,
  input wire logic por_vlevel_sel_o,
  input wire logic mon0_vlevel_sel_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  AST_ACCEPT_GATED: assert property (
    ser_cmd_accept_o |-> serial_mode_i && ser_cmd_valid_i)
    else $error("command accepted without request");
  AST_ID_MISMATCH: assert property (
    id_rx_valid_i && id_rx_i != id_stored_i
    && reset_vector_i != 24'hff_ffff ##1 !id_rx_valid_i
    |-> !ser_cmd_accept_o) else $error("command accepted after bad id");
  AST_ONE_LEVEL: assert property (
    por_vlevel_sel_o == mon0_vlevel_sel_o
    && por_vlevel_sel_o == ^vlevel_sel_o) else $error("level select split");
  AST_BUSY_BIT: assert property (
    rd_i && addr_i == `FRP_ADDR_STATUS |=> rdata_o[7] == $past(read_array_o))
    else $error("ready bit wrong");
  AST_BIT3_ZERO: assert property (
    rd_i && addr_i == `FRP_ADDR_STATUS |=> rdata_o[3] == 1'b0)
    else $error("status bit 3 set");
  AST_HOLD_BUSY: assert property (
    cpu_hold_o |-> port_freeze_o && !read_array_o)
    else $error("hold outside busy");
  AST_IDLE_DATA: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (rd_i && !(addr_i inside {`FRP_ADDR_STATUS,
    `FRP_ADDR_CTRL0, `FRP_ADDR_CTRL2, `FRP_ADDR_OPTION, `FRP_ADDR_CMD})
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  AST_RESET_READY: assert property ($fell(rst_i) |-> read_array_o)
    else $error("not ready after reset");
endmodule
bind frp_flash_ctrl frp_checker #(.ID_BYTES(ID_BYTES)) u_chk (.*);
`default_nettype wire

// ==== sim/frp_prog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module frp_prog_model #(
  parameter ID_BYTES = 7
) (
  input wire logic clk_sys_i,
  input wire logic send_i,
  input wire logic bad_i,
  input wire logic [8*ID_BYTES-1:0] id_ref_i,
  output var logic [8*ID_BYTES-1:0] id_rx_o,
  output var logic id_rx_valid_o,
  output var logic ser_cmd_valid_o
);
  initial begin
    id_rx_o = '0;
    id_rx_valid_o = 1'b0;
    ser_cmd_valid_o = 1'b0;
  end
  // id lines toggle outside a frame so a stale copy never looks valid
  always @(posedge clk_sys_i) begin
    id_rx_valid_o <= send_i;
    ser_cmd_valid_o <= !send_i && (ser_cmd_valid_o || id_rx_valid_o);
    if (send_i) begin
      id_rx_o <= bad_i ? ~id_ref_i : id_ref_i;
    end else begin
      id_rx_o <= ~id_rx_o;
    end
  end
endmodule
`default_nettype wire

// ==== sim/flash_rewrite_protect_status_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "frp_defines.vh"
module flash_rewrite_protect_status_tb;
  logic clk_sys_i, rst_i, wr_i, rd_i, serial_mode_i, id_rx_valid_i;
  logic ser_cmd_valid_i, par_mode_i, par_access_i, block_locked_i;
  logic op_error_i, busy_block_access_i, irq_pending_i, send, bad, rd_seen;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, rdata_o, v;
  logic [23:0] reset_vector_i;
  logic [55:0] id_stored_i, id_rx_i;
  logic ser_cmd_accept_o, par_access_grant_o, read_array_o, cpu_hold_o;
  logic port_freeze_o, watchdog_autostart_sel_o, count_source_protect_init_o;
  logic monitor_reset_start_o, por_vlevel_sel_o, mon0_vlevel_sel_o;
  logic [1:0] vlevel_sel_o;
  logic [15:0] q[$];
  logic [31:0] rnd = 32'h75f9_c653;
  int failures = 0;
  int n_tests = 0;
  int i;
  localparam logic [15:0] ST = `FRP_ADDR_STATUS;
  localparam logic [15:0] C0 = `FRP_ADDR_CTRL0;
  localparam logic [15:0] C2 = `FRP_ADDR_CTRL2;
  localparam logic [15:0] CMD = `FRP_ADDR_CMD;
  // short counts keep each busy phase to a few cycles
  frp_flash_ctrl #(.PROG_CYC(4), .ERASE_CYC(4)) DUT (.*);
  frp_prog_model u_prog (.clk_sys_i(clk_sys_i), .send_i(send), .bad_i(bad),
    .id_ref_i(id_stored_i), .id_rx_o(id_rx_i),
    .id_rx_valid_o(id_rx_valid_i), .ser_cmd_valid_o(ser_cmd_valid_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [7:0] got, exp, mask);
    n_tests++;
    if ((got & mask) !== (exp & mask)) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, m);
    q.push_back({m, e});
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    // sample on the falling edge, where the outputs have settled
    @(negedge clk_sys_i);
    while (read_array_o !== 1'b1 && n < 200) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 200) begin
      failures++;
    end
    @(posedge clk_sys_i);
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // read data stand only in the slot after the strobe
  always @(posedge clk_sys_i) begin
    if (rd_seen) begin
      check(rdata_o, q[0][7:0], q[0][15:8]);
      void'(q.pop_front());
    end
    rd_seen <= rd_i;
  end
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
  initial begin
    {wr_i, rd_i, serial_mode_i, par_mode_i, par_access_i, rd_seen} = '0;
    {block_locked_i, op_error_i, busy_block_access_i, irq_pending_i} = '0;
    {send, bad, addr_i, wdata_i, reset_vector_i, id_stored_i} = '0;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(ST, 8'h80, 8'hfb);
    rd(16'h0100, 8'h00, 8'hff);
    par_mode_i <= 1'b1;
    par_access_i <= 1'b1;
    for (i = 0; i < 4; i++) begin
      wr(C0, 8'h02);
      wr(CMD, 8'h05);
      wait_ready();
      rd(`FRP_ADDR_OPTION, 8'hff, 8'hff);
      rnd = xs(rnd);
      v = {rnd[7:6], i[1:0], i[1:0], rnd[1:0]};
      wr(`FRP_ADDR_OPTION, v);
      check({count_source_protect_init_o, monitor_reset_start_o, vlevel_sel_o,
        3'b000, watchdog_autostart_sel_o}, v & 8'hf1, 8'hff);
      check({5'h00, par_access_grant_o, por_vlevel_sel_o, mon0_vlevel_sel_o},
        {5'h00, !(v[2] & !v[3]), ^v[5:4], ^v[5:4]}, 8'hff);
    end
    wr(C0, 8'h86);
    wr(CMD, 8'h01);
    check({read_array_o, cpu_hold_o, port_freeze_o}, 8'h03, 8'hff);
    wait_ready();
    rd(ST, 8'h81, 8'hfb);
    wr(ST, 8'hff);
    rd(ST, 8'h81, 8'hfb);
    wr(ST, 8'hfe);
    rd(ST, 8'h80, 8'hfb);
    wr(C0, 8'h62);
    op_error_i <= 1'b1;
    busy_block_access_i <= 1'b1;
    wr(CMD, 8'h01);
    wait_ready();
    op_error_i <= 1'b0;
    busy_block_access_i <= 1'b0;
    rd(ST, 8'h92, 8'hfb);
    wr(CMD, 8'h04);
    rd(ST, 8'h80, 8'hfb);
    for (i = 0; i < 2; i++) begin
      wr(C2, i ? 8'h05 : 8'h03);
      wr(C0, i ? 8'h06 : 8'h02);
      irq_pending_i <= i[0];
      wr(CMD, 8'h02);
      wait_ready();
      irq_pending_i <= 1'b0;
      rd(ST, 8'hc0, 8'hfb);
      wr(CMD, 8'h01);
      check({7'h00, read_array_o}, 8'h00, 8'hff);
      wait_ready();
      wr(C2, 8'h00);
      wait_ready();
    end
    block_locked_i <= 1'b1;
    wr(CMD, 8'h03);
    wait_ready();
    rd(ST, 8'h80, 8'hff);
    block_locked_i <= 1'b0;
    wr(CMD, 8'h03);
    wait_ready();
    rd(ST, 8'h84, 8'hff);
    serial_mode_i <= 1'b1;
    for (i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      id_stored_i <= {rnd, rnd[23:0] ^ 24'h5a_5a5a};
      reset_vector_i <= (i == 2) ? 24'hff_ffff : rnd[23:0] & 24'h7f_ffff;
      bad <= (i != 0);
      send <= 1'b1;
      @(posedge clk_sys_i);
      send <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      check({7'h00, ser_cmd_accept_o}, {7'h00, i != 1}, 8'hff);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
